// [include/sfs_defines.vh]
// constants for the startup and fet turn-off sequencer
// Behaviour
// - wake on thermistor-two low or load-detect high
// - aux regulator powered 20 ms after wake
// - init started flag at 23 ms, alarm routable
// - init complete and scan done 47/35 ms
// - full scan done 97/62 ms
// - switch decision at fet time, then every 250 ms tick
// - fets on about 278 ms after wake
// - charge gate off pulls toward stack top
// - discharge gate pulls down until below load-detect
// - resume pulling when gate rises above again
// - pulsing ends after window, then high impedance while gate within margin of load-detect
`ifndef SFS_DEFINES_VH
`define SFS_DEFINES_VH
`define SFS_CLK_MHZ 200
`define SFS_CYC_PER_MS (`SFS_CLK_MHZ * 1000)
`define SFS_CYC_PER_US `SFS_CLK_MHZ
`define SFS_T_REG_MS 20
`define SFS_T_INIT_MS 23
`define SFS_T_COMP_SLOW_MS 47
`define SFS_T_COMP_FAST_MS 35
`define SFS_T_FULL_SLOW_MS 97
`define SFS_T_FULL_FAST_MS 62
`define SFS_T_TICK_MS 250
`define SFS_T_FET_MS 278
`define SFS_T_PULSE_US 150
`define SFS_ADDR_CTRL 8'h00
`define SFS_ADDR_STAT 8'h04
`define SFS_ADDR_IRQ_STAT 8'h08
`define SFS_ADDR_IRQ_EN 8'h0C
`define SFS_ADDR_IRQ_CLR 8'h10
`define SFS_CTRL_FAST 0
`define SFS_CTRL_AUTO_REG 1
`define SFS_CTRL_AUTO_SW 2
`define SFS_CTRL_ALARM_INIT 3
`define SFS_CTRL_CHG_OFF 4
`define SFS_CTRL_DSG_OFF 5
`define SFS_CTRL_RESET 32'h0000_0006
`define SFS_NUM_EVT 6
`endif

// [rtl/sfs_dsg_drv.v]
// discharge gate pulsed turn-off driver
`default_nettype none
module sfs_dsg_drv #(
  parameter PULSE_CYC = 30000
) (
  input wire CLK_SYS, // system clock
  input wire RST_N, // synchronous reset, active low
  input wire off_cmd, // turn-off request level
  input wire gate_above, // gate above load-detect, synchronised
  input wire gate_near, // gate within margin of load-detect
  output reg pull_down, // pull gate toward ground
  output reg hiz, // driver high impedance
  output reg done // one-cycle pulse when pulsing ends
);
  localparam ST_ON = 2'b00;
  localparam ST_PULSE = 2'b01;
  localparam ST_HOLD = 2'b10;
  reg [1:0] st_q;
  reg [31:0] cnt_q;
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st_q <= ST_ON;
      cnt_q <= 32'h0000_0000;
      pull_down <= 1'b0;
      hiz <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_q)
        ST_ON: begin
          hiz <= 1'b0;
          pull_down <= 1'b0;
          if (off_cmd) begin
            st_q <= ST_PULSE;
            cnt_q <= 32'h0000_0000;
            pull_down <= 1'b1;
          end
        end
        ST_PULSE: begin
          cnt_q <= cnt_q + 32'h0000_0001;
          pull_down <= gate_above;
          if (cnt_q == PULSE_CYC - 1) begin
            st_q <= ST_HOLD;
            pull_down <= 1'b0;
            hiz <= gate_near;
            done <= 1'b1;
          end
        end
        ST_HOLD: begin
          hiz <= gate_near;
          pull_down <= ~gate_near & gate_above;
          if (!off_cmd) begin
            st_q <= ST_ON;
          end
        end
        default: begin
          st_q <= ST_ON;
        end
      endcase
    end
  end
endmodule // sfs_dsg_drv
`default_nettype wire

// [rtl/sfs_sync.v]
// three-stage synchroniser for pin inputs
`default_nettype none
module sfs_sync (
  input wire CLK_SYS, // system clock
  input wire RST_N, // synchronous reset, active low
  input wire din, // asynchronous input
  output reg dout // filtered level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule // sfs_sync
`default_nettype wire

// [rtl/sfs_top.v]
// startup sequencer with fet turn-off and ahb-lite registers
`include "sfs_defines.vh"
`default_nettype none
module sfs_top #(
  parameter REG_CYC = `SFS_T_REG_MS * `SFS_CYC_PER_MS,
  parameter INIT_CYC = `SFS_T_INIT_MS * `SFS_CYC_PER_MS,
  parameter COMP_SLOW_CYC = `SFS_T_COMP_SLOW_MS * `SFS_CYC_PER_MS,
  parameter COMP_FAST_CYC = `SFS_T_COMP_FAST_MS * `SFS_CYC_PER_MS,
  parameter FULL_SLOW_CYC = `SFS_T_FULL_SLOW_MS * `SFS_CYC_PER_MS,
  parameter FULL_FAST_CYC = `SFS_T_FULL_FAST_MS * `SFS_CYC_PER_MS,
  parameter FET_CYC = `SFS_T_FET_MS * `SFS_CYC_PER_MS,
  parameter TICK_CYC = `SFS_T_TICK_MS * `SFS_CYC_PER_MS,
  parameter PULSE_CYC = `SFS_T_PULSE_US * `SFS_CYC_PER_US
) (
  input wire CLK_SYS, // system clock 200 MHz
  input wire RST_N, // synchronous reset, active low
  input wire HSEL, // ahb select
  input wire [31:0] HADDR, // ahb address
  input wire [1:0] HTRANS, // ahb transfer type
  input wire HWRITE, // ahb write
  input wire [2:0] HSIZE, // ahb size
  input wire [31:0] HWDATA, // ahb write data
  input wire HREADY, // ahb bus ready
  output wire HREADYOUT, // ahb slave ready
  output wire HRESP, // ahb response
  output reg [31:0] HRDATA, // ahb read data
  input wire THERMISTOR_TWO_PIN, // wake when low
  input wire LOAD_DETECT_PIN, // wake when high
  input wire DSG_ABOVE_LD, // comparator: gate above load-detect
  input wire DSG_NEAR_LD, // comparator: gate within margin
  output reg AUX_REGULATOR_OUTPUT, // aux regulator enable
  output reg ALARM_N, // alarm pin, low when active
  output reg CHARGE_GATE_ON, // charge pump drive for charge gate
  output reg CHARGE_GATE_TO_STACK, // switch gate to stack top
  output reg DISCHARGE_GATE_ON, // charge pump drive for discharge gate
  output wire DISCHARGE_GATE_PULL, // pull discharge gate to ground
  output wire DISCHARGE_GATE_HIZ, // discharge driver high impedance
  output wire IRQ // interrupt level
);
  ////////////////////////////////////////////////////////////////////
  localparam ST_SHUT = 2'b00;
  localparam ST_START = 2'b01;
  localparam ST_NORMAL = 2'b10;
  reg [1:0] st_q;
  reg [31:0] tmr_q;
  reg [31:0] tick_q;
  reg init_started_flag_q;
  reg init_complete_flag_q;
  reg conversion_scan_done_flag_q;
  reg full_scan_done_flag_q;
  reg fets_on_q;
  reg [31:0] ctrl_q;
  reg [`SFS_NUM_EVT-1:0] irq_stat_q;
  reg [`SFS_NUM_EVT-1:0] irq_en_q;
  reg [`SFS_NUM_EVT-1:0] evt;
  wire ts2_s;
  wire ld_s;
  wire dsg_above_s;
  wire dsg_near_s;
  wire dsg_done;
  wire fast_conversion_select = ctrl_q[`SFS_CTRL_FAST];
  wire auto_reg = ctrl_q[`SFS_CTRL_AUTO_REG];
  wire autonomous_switch_enable = ctrl_q[`SFS_CTRL_AUTO_SW];
  wire alarm_init = ctrl_q[`SFS_CTRL_ALARM_INIT];
  wire chg_off = ctrl_q[`SFS_CTRL_CHG_OFF];
  wire dsg_off = ctrl_q[`SFS_CTRL_DSG_OFF];
  wire [31:0] comp_cyc = fast_conversion_select ? COMP_FAST_CYC : COMP_SLOW_CYC;
  wire [31:0] full_cyc = fast_conversion_select ? FULL_FAST_CYC : FULL_SLOW_CYC;
  // first decision lands at fet time, later ones every tick after it
  wire [31:0] first_tick = FET_CYC;
  ////////////////////////////////////////////////////////////////////
  sfs_sync u_ts2 (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .din(THERMISTOR_TWO_PIN), .dout(ts2_s));
  sfs_sync u_ld (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .din(LOAD_DETECT_PIN), .dout(ld_s));
  sfs_sync u_ab (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .din(DSG_ABOVE_LD), .dout(dsg_above_s));
  sfs_sync u_nr (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .din(DSG_NEAR_LD), .dout(dsg_near_s));
  sfs_dsg_drv #(.PULSE_CYC(PULSE_CYC)) u_dsg (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .off_cmd(dsg_off),
    .gate_above(dsg_above_s),
    .gate_near(dsg_near_s),
    .pull_down(DISCHARGE_GATE_PULL),
    .hiz(DISCHARGE_GATE_HIZ),
    .done(dsg_done)
  );
  // ts2 synchroniser resets low, so wake waits for it to read high first
  reg ts2_seen_q;
  ////////////////////////////////////////////////////////////////////
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st_q <= ST_SHUT;
      tmr_q <= 32'h0000_0000;
      tick_q <= 32'h0000_0000;
      ts2_seen_q <= 1'b0;
      AUX_REGULATOR_OUTPUT <= 1'b0;
      init_started_flag_q <= 1'b0;
      init_complete_flag_q <= 1'b0;
      conversion_scan_done_flag_q <= 1'b0;
      full_scan_done_flag_q <= 1'b0;
      fets_on_q <= 1'b0;
    end else begin
      if (ts2_s) begin
        ts2_seen_q <= 1'b1;
      end
      case (st_q)
        ST_SHUT: begin
          tmr_q <= 32'h0000_0000;
          if ((ts2_seen_q && !ts2_s) || ld_s) begin
            st_q <= ST_START;
          end
        end
        ST_START, ST_NORMAL: begin
          tmr_q <= tmr_q + 32'h0000_0001;
          if (auto_reg && tmr_q == REG_CYC - 1) begin
            AUX_REGULATOR_OUTPUT <= 1'b1;
          end
          if (tmr_q == INIT_CYC - 1) begin
            init_started_flag_q <= 1'b1;
          end
          if (tmr_q == comp_cyc - 1) begin
            init_complete_flag_q <= 1'b1;
            conversion_scan_done_flag_q <= 1'b1;
          end
          if (tmr_q == full_cyc - 1) begin
            full_scan_done_flag_q <= 1'b1;
            st_q <= ST_NORMAL;
          end
          if (st_q == ST_NORMAL) begin
            tick_q <= tick_q + 32'h0000_0001;
            if (tmr_q == first_tick - 1 || tick_q == TICK_CYC - 1) begin
              tick_q <= 32'h0000_0000;
              if (autonomous_switch_enable && full_scan_done_flag_q) begin
                fets_on_q <= 1'b1;
              end
            end
          end
          if (tmr_q == 32'hFFFF_FFFE) begin
            tmr_q <= tmr_q;
          end
        end
        default: begin
          st_q <= ST_SHUT;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      CHARGE_GATE_ON <= 1'b0;
      CHARGE_GATE_TO_STACK <= 1'b0;
      DISCHARGE_GATE_ON <= 1'b0;
      ALARM_N <= 1'b1;
    end else begin
      CHARGE_GATE_ON <= fets_on_q & ~chg_off;
      CHARGE_GATE_TO_STACK <= chg_off;
      DISCHARGE_GATE_ON <= fets_on_q & ~dsg_off;
      ALARM_N <= ~(alarm_init & init_started_flag_q);
    end
  end
  ////////////////////////////////////////////////////////////////////
  reg prev_init_q;
  reg prev_comp_q;
  reg prev_full_q;
  reg prev_fet_q;
  reg prev_reg_q;
  always @* begin
    evt = {dsg_done, fets_on_q & ~prev_fet_q, full_scan_done_flag_q & ~prev_full_q,
           init_complete_flag_q & ~prev_comp_q, init_started_flag_q & ~prev_init_q,
           AUX_REGULATOR_OUTPUT & ~prev_reg_q};
  end
  ////////////////////////////////////////////////////////////////////
  reg dph_q;
  reg dwr_q;
  reg [7:0] daddr_q;
  wire take = HSEL & HREADY & HTRANS[1];
  wire wr_now = dph_q & dwr_q;
  wire [`SFS_NUM_EVT-1:0] clr_bits =
    (wr_now && daddr_q == `SFS_ADDR_IRQ_CLR) ? HWDATA[`SFS_NUM_EVT-1:0] : {`SFS_NUM_EVT{1'b0}};
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign IRQ = |(irq_stat_q & irq_en_q);
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      dph_q <= 1'b0;
      dwr_q <= 1'b0;
      daddr_q <= 8'h00;
      HRDATA <= 32'h0000_0000;
      ctrl_q <= `SFS_CTRL_RESET;
      irq_stat_q <= {`SFS_NUM_EVT{1'b0}};
      irq_en_q <= {`SFS_NUM_EVT{1'b0}};
      prev_init_q <= 1'b0;
      prev_comp_q <= 1'b0;
      prev_full_q <= 1'b0;
      prev_fet_q <= 1'b0;
      prev_reg_q <= 1'b0;
    end else begin
      prev_init_q <= init_started_flag_q;
      prev_comp_q <= init_complete_flag_q;
      prev_full_q <= full_scan_done_flag_q;
      prev_fet_q <= fets_on_q;
      prev_reg_q <= AUX_REGULATOR_OUTPUT;
      dph_q <= take;
      dwr_q <= HWRITE;
      daddr_q <= HADDR[7:0];
      // set wins over clear
      irq_stat_q <= (irq_stat_q & ~clr_bits) | evt;
      if (wr_now && daddr_q == `SFS_ADDR_CTRL) begin
        ctrl_q <= {26'h000_0000, HWDATA[5:0]};
      end
      if (wr_now && daddr_q == `SFS_ADDR_IRQ_EN) begin
        irq_en_q <= HWDATA[`SFS_NUM_EVT-1:0];
      end
      if (take && !HWRITE) begin
        case (HADDR[7:0])
          `SFS_ADDR_CTRL: HRDATA <= ctrl_q;
          `SFS_ADDR_STAT: HRDATA <= {24'h00_0000, DISCHARGE_GATE_HIZ, fets_on_q,
            full_scan_done_flag_q, conversion_scan_done_flag_q, init_complete_flag_q,
            init_started_flag_q, st_q};
          `SFS_ADDR_IRQ_STAT: HRDATA <= {26'h000_0000, irq_stat_q};
          `SFS_ADDR_IRQ_EN: HRDATA <= {26'h000_0000, irq_en_q};
          default: HRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // sfs_top
`default_nettype wire

// [tb/sfs_pin_model.sv]
// wake pins and discharge gate voltage model
`default_nettype none
module sfs_pin_model (
  input wire logic clk, // clock
  input wire logic ts2_low, // pull thermistor pin low
  input wire logic ld_up, // pull load pin up
  input wire logic relax, // gate drifts back up when released
  input wire logic dsg_on, // gate driven on
  input wire logic dsg_pull, // gate pulled down
  output logic ts2, // thermistor pin
  output logic ld, // load pin
  output logic above, // gate above load level
  output logic near // gate close to load level
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LD_LVL = 20;
  int v = 0;
  assign ts2 = !ts2_low;
  assign ld = ld_up;
  assign above = v > LD_LVL;
  assign near = v < LD_LVL + 16;
  always @(posedge clk) begin
    if (dsg_on) v <= 100;
    else if (dsg_pull) v <= v - 3;
    else if (relax && v < LD_LVL + 6) v <= v + 1;
  end
endmodule // sfs_pin_model
`default_nettype wire

// [tb/sfs_top_assertions.sv]
// concurrent checks on the sequencer top ports
`default_nettype none
module sfs_checker (
  input wire logic CLK_SYS, // clock
  input wire logic RST_N, // reset
  input wire logic HSEL, // select
  input wire logic [31:0] HADDR, // address
  input wire logic [1:0] HTRANS, // transfer
  input wire logic HWRITE, // write
  input wire logic HREADY, // ready in
  input wire logic [31:0] HWDATA, // write data
  input wire logic HREADYOUT, // ready out
  input wire logic HRESP, // response
  input wire logic [31:0] HRDATA, // read data
  input wire logic DSG_ABOVE_LD, // comparator
  input wire logic AUX_REGULATOR_OUTPUT, // regulator
  input wire logic CHARGE_GATE_ON, // chg drive
  input wire logic CHARGE_GATE_TO_STACK, // chg switch
  input wire logic DISCHARGE_GATE_ON, // dsg drive
  input wire logic DISCHARGE_GATE_PULL, // dsg pull
  input wire logic DISCHARGE_GATE_HIZ // dsg hiz
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  wire take = HSEL && HREADY && HTRANS[1];
  AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or error");
  AST_UNMAPPED_ZERO: assert property (take && !HWRITE && HADDR == 32'h14 |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  AST_CHG_SWITCH: assert property (
    take && HWRITE && HADDR == 32'h0 |-> ##3 CHARGE_GATE_TO_STACK == $past(HWDATA[4], 2))
    else $error("charge gate switch does not follow control");
  AST_CHG_OFF: assert property (CHARGE_GATE_TO_STACK [*2] |-> !CHARGE_GATE_ON)
    else $error("charge gate driven while switched to stack");
  AST_DSG_OFF: assert property (DISCHARGE_GATE_PULL [*2] |-> !DISCHARGE_GATE_ON)
    else $error("discharge gate driven while pulled down");
  AST_DSG_STOP: assert property (
    (DISCHARGE_GATE_PULL && !DSG_ABOVE_LD) [*8] |-> ##[1:4] !DISCHARGE_GATE_PULL)
    else $error("discharge pull continues below load level");
  AST_PULL_HIZ: assert property (!(DISCHARGE_GATE_PULL && DISCHARGE_GATE_HIZ))
    else $error("discharge pull and high impedance together");
  AST_REG_HOLD: assert property (
    $rose(AUX_REGULATOR_OUTPUT) |=> $stable(AUX_REGULATOR_OUTPUT) [*4])
    else $error("regulator output not held");
  cover property ($rose(DISCHARGE_GATE_HIZ));
  cover property ($rose(CHARGE_GATE_ON));
  cover property ($fell(DISCHARGE_GATE_PULL));
endmodule // sfs_checker
bind sfs_top sfs_checker u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .HRDATA(HRDATA), .DSG_ABOVE_LD(DSG_ABOVE_LD),
  .AUX_REGULATOR_OUTPUT(AUX_REGULATOR_OUTPUT), .CHARGE_GATE_ON(CHARGE_GATE_ON),
  .CHARGE_GATE_TO_STACK(CHARGE_GATE_TO_STACK), .DISCHARGE_GATE_ON(DISCHARGE_GATE_ON),
  .DISCHARGE_GATE_PULL(DISCHARGE_GATE_PULL), .DISCHARGE_GATE_HIZ(DISCHARGE_GATE_HIZ));
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the startup and fet turn-off sequencer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} sfs_row_t;
  logic clk, rst_n, hsel, hwrite, ts2_low, ld_up, relax;
  localparam int T_REG = 20, T_INIT = 23, T_CS = 47, T_CF = 35, T_FS = 97, T_FF = 62;
  localparam int T_FET = 278, T_TICK = 250, T_PUL = 150;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, rd;
  wire logic hreadyout, hresp, ts2, ldp, above, near, aux, alarm_n, cg_on, cg_st, dg_on, dg_p;
  wire logic dg_z, irq;
  wire logic [31:0] hrdata;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int n_pul = 0;
  int wake, t_aux, t_alm, p0;
  logic aux_q = 0, alm_q = 1, dgp_q = 0;
  sfs_row_t rows[8] = '{'{0, 32'h0, 32'h0, 32'h6}, '{0, 32'h4, 32'h0, 32'h0},
    '{0, 32'h8, 32'h0, 32'h0}, '{1, 32'hC, 32'h3F, 32'h0}, '{0, 32'hC, 32'h0, 32'h3F},
    '{1, 32'h4, 32'hFF, 32'h0}, '{0, 32'h4, 32'h0, 32'h0}, '{0, 32'h14, 32'h0, 32'h0}};
  sfs_top #(.REG_CYC(T_REG), .INIT_CYC(T_INIT), .COMP_SLOW_CYC(T_CS), .COMP_FAST_CYC(T_CF),
    .FULL_SLOW_CYC(T_FS), .FULL_FAST_CYC(T_FF), .FET_CYC(T_FET), .TICK_CYC(T_TICK),
    .PULSE_CYC(T_PUL)) dut (
    .CLK_SYS(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .THERMISTOR_TWO_PIN(ts2),
    .LOAD_DETECT_PIN(ldp), .DSG_ABOVE_LD(above), .DSG_NEAR_LD(near),
    .AUX_REGULATOR_OUTPUT(aux), .ALARM_N(alarm_n), .CHARGE_GATE_ON(cg_on),
    .CHARGE_GATE_TO_STACK(cg_st), .DISCHARGE_GATE_ON(dg_on), .DISCHARGE_GATE_PULL(dg_p),
    .DISCHARGE_GATE_HIZ(dg_z), .IRQ(irq));
  sfs_pin_model pins (.clk(clk), .ts2_low(ts2_low), .ld_up(ld_up), .relax(relax),
    .dsg_on(dg_on), .dsg_pull(dg_p), .ts2(ts2), .ld(ldp), .above(above), .near(near));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    aux_q <= aux;
    alm_q <= alarm_n;
    dgp_q <= dg_p;
    if (aux && !aux_q) t_aux <= cyc;
    if (!alarm_n && alm_q) t_alm <= cyc;
    if (dg_p && !dgp_q) n_pul <= n_pul + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rng(string n, int lo, int t);
    comparisons++;
    if (t < lo || t > lo + 10) begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", n, lo, t);
    end
  endtask
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    hsel <= 1;
    hsize <= 3'h2;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge clk);
    while (hreadyout !== 1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic await(logic [31:0] m, int n);
    int k;
    k = 0;
    rd = 0;
    while ((rd & m) !== m && k < 400) begin
      bus(0, 32'h4, 32'h0);
      k++;
    end
    rng("stat_time", n, cyc - wake);
  endtask
  task automatic rst;
    rst_n <= 0;
    repeat (4) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, hsel, hwrite, ts2_low, ld_up, relax} = 0;
    htrans = 0;
    hsize = 3'h2;
    haddr = 0;
    hwdata = 0;
    rst;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("reg", rows[i].e, rd);
    end
    chk("irq_idle", 0, irq);
    bus(1, 32'h0, 32'hE);
    repeat (8) @(posedge clk);
    ts2_low <= 1;
    wake = cyc;
    await(32'h18, 47);
    await(32'h20, 97);
    await(32'h42, 278);
    chk("stat", 32'h7E, rd);
    rng("aux", 20, t_aux - wake);
    rng("alarm", 23, t_alm - wake);
    bus(0, 32'h8, 32'h0);
    chk("irq_stat", 32'h1F, rd);
    chk("irq", 1, irq);
    bus(1, 32'hC, 32'h0);
    @(posedge clk);
    chk("irq_mask", 0, irq);
    bus(1, 32'hC, 32'h3F);
    bus(1, 32'h10, 32'h1F);
    @(posedge clk);
    chk("irq_clr", 0, irq);
    relax <= 1;
    bus(1, 32'h0, 32'h2E);
    p0 = n_pul;
    wake = cyc;
    for (int k = 0; k < 400 && dg_z !== 1; k++) @(posedge clk);
    rng("hiz", 150, cyc - wake);
    chk("pulses", 1, n_pul - p0 > 2);
    chk("dsg_pull", 0, dg_p);
    chk("dsg_on", 0, dg_on);
    bus(0, 32'h8, 32'h0);
    chk("dsg_done", 32'h20, rd);
    bus(1, 32'h0, 32'h3E);
    repeat (3) @(posedge clk);
    chk("chg_stack", 1, cg_st);
    chk("chg_on", 0, cg_on);
    relax <= 0;
    ts2_low <= 0;
    rst;
    chk("rst_aux", 0, aux);
    chk("rst_alarm", 1, alarm_n);
    chk("rst_chg_stack", 0, cg_st);
    chk("rst_dsg_hiz", 0, dg_z);
    bus(1, 32'h0, 32'h3);
    repeat (8) @(posedge clk);
    ld_up <= 1;
    wake = cyc;
    await(32'h18, 35);
    await(32'h20, 62);
    rng("aux_fast", 20, t_aux - wake);
    while (cyc - wake < 300) @(posedge clk);
    bus(1, 32'h0, 32'h7);
    await(32'h42, 528);
    close_out;
  end
  initial begin
    #20000;
    fail_count++;
    close_out;
  end
endmodule // testbench
`default_nettype wire
